// ==== logic/sbc_spi_regs.sv ====
// Serial command decoder and control/status register bank
`timescale 1ns/1ps
module sbc_spi_regs
   import sbc_spi_pkg::*;
#(
   parameter logic [7:0] FAMILY_ID = 8'h5a // Arbitrary value
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial link pins
   input wire logic spi_cs_n,
   input wire logic spi_clk,
   input wire logic spi_din,
   output logic spi_dout,
   output logic spi_dout_oe,
   // Device mode
   input wire logic soft_reset,
   input wire logic restart_active,
   // Hardware side
   input wire hw_upd_type hw_upd,
   input wire logic [STAT_REGS-1:0][7:0] stat_set,
   input wire logic [LIVE_REGS-1:0][7:0] live_status,
   // Register contents
   output logic [CTRL_REGS-1:0][7:0] ctrl_q,
   output logic [7:0] status_field,
   output cmd_event_type cmd_event
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic sclk_d_r;
   logic [LIVE_REGS-1:0][7:0] live_s1_r;
   logic [LIVE_REGS-1:0][7:0] live_s2_r;
   logic cs_idle;
   logic sclk_lvl;
   logic din_lvl;
   logic sclk_rise;
   logic sclk_fall;
   link_state_type state_r;
   logic [4:0] cnt_r;
   logic [FRAME_BITS-1:0] rx_r;
   logic [7:0] rd_byte_r;
   logic [7:0] field_r;
   logic [7:0] status_field_r;
   logic [7:0] status_field_nxt;
   logic sdo_r;
   logic restart_d_r;
   logic restart_rise;
   logic commit;
   logic wr_hit;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   reg_attr_type rd_ca;
   reg_attr_type rd_sa;
   logic [CTRL_REGS-1:0][7:0] ctrl_r;
   logic [STAT_REGS-1:0][7:0] stat_r;
   cmd_event_type cmd_event_r;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Two stages before any logic looks at a pin
   // Reset to the idle pin levels (select high, clock low) so no false clock edge follows reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_s1_r <= 3'h4;
         pin_s2_r <= 3'h4;
         sclk_d_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= {spi_cs_n, spi_clk, spi_din};
         pin_s2_r <= pin_s1_r;
         sclk_d_r <= pin_s2_r[1];
      end
   end

   // Live level and selective wake status come from outside the clock domain
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         live_s1_r <= '0;
         live_s2_r <= '0;
      end
      else
      begin
         live_s1_r <= live_status;
         live_s2_r <= live_s1_r;
      end
   end

   assign cs_idle = pin_s2_r[2];
   assign sclk_lvl = pin_s2_r[1];
   assign din_lvl = pin_s2_r[0];
   // Edge finding; link clock at 64 ns gives eight samples per period
   assign sclk_rise = sclk_lvl & ~sclk_d_r;
   assign sclk_fall = ~sclk_lvl & sclk_d_r;
   assign restart_rise = restart_active & ~restart_d_r;

   // Frame accepted only with exactly sixteen clocks and chip select back high
   assign commit = (state_r == ST_FRAME) && cs_idle && (cnt_r == 5'(FRAME_BITS)) && !restart_active;
   assign wr_hit = commit && rx_r[ACCESS_POS];
   assign wr_addr = rx_r[6:0];
   assign wr_data = rx_r[FRAME_BITS-1:DATA_POS];

   // ****************************************
   // Link state machine
   // ****************************************
   // Restart aborts any frame; the rest is dropped until chip select is high and restart has ended
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         rx_r <= '0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (!cs_idle)
               begin
                  state_r <= restart_active ? ST_IGNORE : ST_FRAME;
                  cnt_r <= '0;
                  rx_r <= '0;
               end
            end
            ST_FRAME:
            begin
               if (restart_active)
                  state_r <= ST_IGNORE;
               else if (cs_idle)
                  state_r <= ST_IDLE;
               else if (sclk_rise && cnt_r <= 5'(FRAME_BITS))
               begin
                  // Counter parks one past the frame so long frames are refused
                  if (cnt_r < 5'(FRAME_BITS))
                     rx_r[cnt_r[3:0]] <= din_lvl;
                  cnt_r <= cnt_r + 5'd1;
               end
            end
            ST_IGNORE:
            begin
               if (cs_idle && !restart_active)
                  state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Read data path
   // ****************************************
   // Address is complete once seven bits are in
   always_comb
   begin
      rd_addr = rx_r[6:0];
      rd_data = '0;
      rd_ca = ctrl_attr(rd_addr[5:0]);
      rd_sa = stat_attr(rd_addr[4:0]);
      if (!rd_addr[6])
      begin
         if (rd_ca.exists)
            rd_data = ctrl_r[rd_addr[5:0]] & (rd_ca.wmask | rd_ca.hwmask);
      end
      else
      begin
         case (rd_addr)
            ADDR_WAKE_LEVEL: rd_data = live_s2_r[0] & LIVE_MASK[0];
            ADDR_SWK_STATUS: rd_data = live_s2_r[1] & LIVE_MASK[1];
            ADDR_SWK_ERR_COUNT: rd_data = live_s2_r[2] & LIVE_MASK[2];
            ADDR_CDR_STAT_FIRST: rd_data = live_s2_r[3] & LIVE_MASK[3];
            ADDR_CDR_STAT_SECOND: rd_data = live_s2_r[4] & LIVE_MASK[4];
            ADDR_FAMILY_ID: rd_data = FAMILY_ID;
            default:
            begin
               if (in_stat(rd_addr) && rd_sa.exists)
                  rd_data = stat_r[rd_addr[4:0]] & rd_sa.wmask;
            end
         endcase
      end
   end

   // Old content is captured before any write lands, so a new setting shows next frame
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rd_byte_r <= '0;
      else if (state_r == ST_IDLE && !cs_idle)
         rd_byte_r <= '0;
      else if (state_r == ST_FRAME && sclk_rise && cnt_r == 5'(ACCESS_POS))
         rd_byte_r <= rd_data;
   end

   // Compressed status summary: eight bits over nine status registers, both wake registers on bit 4
   always_comb
   begin
      status_field_nxt[0] = |stat_r[ADDR_SUP_FIRST[4:0]];
      status_field_nxt[1] = |stat_r[ADDR_THERMAL[4:0]];
      status_field_nxt[2] = |stat_r[ADDR_DEVICE[4:0]];
      status_field_nxt[3] = |stat_r[ADDR_BUS_STAT[4:0]];
      status_field_nxt[4] = |(stat_r[ADDR_WAKE_FIRST[4:0]] | stat_r[ADDR_WAKE_SECOND[4:0]]);
      status_field_nxt[5] = |stat_r[ADDR_SUP_SECOND[4:0]];
      status_field_nxt[6] = |stat_r[ADDR_SW_OVERLOAD[4:0]];
      status_field_nxt[7] = |stat_r[ADDR_SW_OPEN_LOAD[4:0]];
   end

   // Summary frozen at frame start so the low byte is coherent
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status_field_r <= '0;
         field_r <= '0;
      end
      else
      begin
         status_field_r <= status_field_nxt;
         if (state_r == ST_IDLE && !cs_idle)
            field_r <= status_field_r;
      end
   end

   // Serial out, least significant bit first, changed on falling link clock
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sdo_r <= 1'b0;
      else if (state_r == ST_IDLE && !cs_idle)
         sdo_r <= status_field_r[0];
      else if (state_r == ST_FRAME && sclk_fall && cnt_r != '0 && cnt_r < 5'(FRAME_BITS))
         sdo_r <= (cnt_r < 5'(DATA_POS)) ? field_r[cnt_r[2:0]] : rd_byte_r[cnt_r[2:0]];
   end

   assign spi_dout = sdo_r;
   assign spi_dout_oe = (state_r == ST_FRAME);

   // ****************************************
   // Control registers
   // ****************************************
   // Hardware update lands after the master write, so the latest value wins
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_reset)
      begin
         for (int i = 0; i < CTRL_REGS; i++)
            ctrl_r[i] <= ctrl_attr(6'(i)).por;
      end
      else if (restart_rise)
      begin
         for (int i = 0; i < CTRL_REGS; i++)
            ctrl_r[i] <= (ctrl_r[i] & ctrl_attr(6'(i)).keep) | (ctrl_attr(6'(i)).rst & ~ctrl_attr(6'(i)).keep);
      end
      else
      begin
         for (int i = 0; i < CTRL_REGS; i++)
         begin
            automatic logic [7:0] v = ctrl_r[i];
            automatic reg_attr_type a = ctrl_attr(6'(i));
            if (wr_hit && !wr_addr[6] && wr_addr[5:0] == 6'(i) && a.exists)
               v = (v & ~a.wmask) | (wr_data & a.wmask);
            if (hw_upd.valid && !hw_upd.addr[6] && hw_upd.addr[5:0] == 6'(i))
               v = (v & ~a.hwmask) | (hw_upd.data & a.hwmask);
            ctrl_r[i] <= v;
         end
      end
   end

   assign ctrl_q = ctrl_r;

   // ****************************************
   // Status registers
   // ****************************************
   // A set in the clearing cycle survives; restart leaves flags alone
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_reset)
         stat_r <= '0;
      else
      begin
         for (int i = 0; i < STAT_REGS; i++)
         begin
            automatic logic [7:0] v = stat_r[i];
            automatic reg_attr_type a = stat_attr(5'(i));
            if (wr_hit && in_stat(wr_addr) && wr_addr[4:0] == 5'(i))
               v = v & ~a.wmask;
            stat_r[i] <= v | (stat_set[i] & a.wmask);
         end
      end
   end

   // ****************************************
   // Command event and restart edge
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cmd_event_r <= '0;
         restart_d_r <= 1'b0;
      end
      else
      begin
         cmd_event_r <= '{valid: commit, write: rx_r[ACCESS_POS], addr: wr_addr};
         restart_d_r <= restart_active;
      end
   end

   assign cmd_event = cmd_event_r;
   assign status_field = status_field_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_quiet;
      !soft_reset && !restart_rise && !hw_upd.valid;
   endsequence

   sequence seq_write(logic [6:0] a);
      wr_hit && wr_addr == a;
   endsequence

   sequence seq_data_start;
      state_r == ST_FRAME && sclk_fall && cnt_r == 5'(DATA_POS);
   endsequence

   write_whole_byte_a: assert property (seq_write(ADDR_BUS_SECOND) ##0 seq_quiet |=>
      ctrl_r[ADDR_BUS_SECOND[5:0]] == $past(wr_data))
      else $error("write did not store the whole data byte");

   read_keeps_reg_a: assert property (commit && !rx_r[ACCESS_POS] ##0 seq_quiet |=> $stable(ctrl_r))
      else $error("read command changed a control register");

   reserved_zero_a: assert property (ctrl_r[ADDR_BUS_FIRST[5:0]][7:3] == 5'h00
      && ctrl_r[ADDR_WATCHDOG[5:0]][3] == 1'b0)
      else $error("reserved control bit became set");

   hw_modify_a: assert property (hw_upd.valid && hw_upd.addr == ADDR_MODE_SUPPLY && !soft_reset
      && !restart_rise |=> ctrl_r[ADDR_MODE_SUPPLY[5:0]][7:2] == $past(hw_upd.data[7:2]))
      else $error("hardware update not visible");

   soft_reset_a: assert property (soft_reset |=> ctrl_r[ADDR_WATCHDOG[5:0]] == 8'h14
      && ctrl_r[ADDR_MODE_SUPPLY[5:0]] == 8'h00 && stat_r == '0)
      else $error("soft reset values not loaded");

   restart_load_a: assert property (restart_rise && !soft_reset |=>
      ctrl_r[ADDR_WATCHDOG[5:0]][3:0] == 4'h4 && ctrl_r[ADDR_WATCHDOG[5:0]][6] == 1'b0
      && ctrl_r[ADDR_WATCHDOG[5:0]][7] == $past(ctrl_r[ADDR_WATCHDOG[5:0]][7]))
      else $error("restart values not loaded");

   status_clear_a: assert property (seq_write(ADDR_SUP_FIRST) ##0 !soft_reset |=>
      stat_r[ADDR_SUP_FIRST[4:0]] == $past(stat_set[ADDR_SUP_FIRST[4:0]]))
      else $error("status clear lost or set event dropped");

   restart_ignore_a: assert property (restart_active |=> state_r != ST_FRAME ##1 !cmd_event.valid)
      else $error("command taken during restart");

   unmapped_zero_a: assert property (state_r == ST_FRAME && sclk_rise && cnt_r == 5'(ACCESS_POS)
      && rx_r[6:0] == ADDR_UNMAPPED |=> rd_byte_r == 8'h00)
      else $error("unmapped address returned data");

   data_map_a: assert property (seq_data_start |=> spi_dout == rd_byte_r[0])
      else $error("data byte not placed at frame bit eight");

endmodule : sbc_spi_regs

// ==== logic/sbc_spi_pkg.sv ====
// Constants, types and register attribute tables for the serial register bank
// Behaviour
// - Frame is sixteen bits: address, mode, data
// - Data byte sits in frame bits eight-fifteen
// - Mode bit zero only reads the register
// - Mode bit one writes whole data byte
// - Reserved bits always read back as zero
// - Read-only bits ignore any write data
// - Read/write bits hold last written value
// - Hardware-modifiable bits take master and hardware updates
// - Control bits change only by writes, except hardware
// - Reset or soft reset loads power-on values
// - Restart loads restart values, don't-care bits kept
// - One whole register per command, never parts
// - Status write with mode one clears bits
// - Level, identifier, selective wake status not clearable
// - New setting visible on next command only
// - Commands ignored while restart is active
package sbc_spi_pkg;

   // ****************************************
   // Frame layout
   // ****************************************
   localparam int FRAME_BITS = 16;
   localparam int ACCESS_POS = 7;
   localparam int DATA_POS = 8;
   localparam int CTRL_REGS = 64;
   localparam int STAT_REGS = 22;
   localparam int LIVE_REGS = 5;

   // ****************************************
   // Addresses that logic refers to by name
   // ****************************************
   localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
   localparam logic [6:0] ADDR_WATCHDOG = 7'h03;
   localparam logic [6:0] ADDR_BUS_FIRST = 7'h04;
   localparam logic [6:0] ADDR_BUS_SECOND = 7'h05;
   localparam logic [6:0] ADDR_SUP_SECOND = 7'h40;
   localparam logic [6:0] ADDR_SUP_FIRST = 7'h41;
   localparam logic [6:0] ADDR_THERMAL = 7'h42;
   localparam logic [6:0] ADDR_DEVICE = 7'h43;
   localparam logic [6:0] ADDR_BUS_STAT = 7'h44;
   localparam logic [6:0] ADDR_WAKE_FIRST = 7'h46;
   localparam logic [6:0] ADDR_WAKE_SECOND = 7'h47;
   localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
   localparam logic [6:0] ADDR_SW_OVERLOAD = 7'h54;
   localparam logic [6:0] ADDR_SW_OPEN_LOAD = 7'h55;
   localparam logic [6:0] ADDR_SWK_STATUS = 7'h70;
   localparam logic [6:0] ADDR_SWK_ERR_COUNT = 7'h71;
   localparam logic [6:0] ADDR_CDR_STAT_FIRST = 7'h72;
   localparam logic [6:0] ADDR_CDR_STAT_SECOND = 7'h73;
   localparam logic [6:0] ADDR_FAMILY_ID = 7'h7e;
   localparam logic [6:0] ADDR_UNMAPPED = 7'h7f;
   localparam logic [6:0] STAT_BASE = 7'h40;

   // Readable bits of the live registers, index order as the addresses above
   localparam logic [LIVE_REGS-1:0][7:0] LIVE_MASK = {8'hf0, 8'hff, 8'h3f, 8'h4f, 8'hf7};

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic exists;
      logic [7:0] wmask;
      logic [7:0] hwmask;
      logic [7:0] por;
      logic [7:0] keep;
      logic [7:0] rst;
   } reg_attr_type;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } hw_upd_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] addr;
   } cmd_event_type;

   typedef enum {ST_IDLE, ST_FRAME, ST_IGNORE} link_state_type;

   // Control register attributes; keep marks bits unchanged by restart
   function automatic reg_attr_type ctrl_attr(input logic [5:0] idx);
      reg_attr_type a;
      a = '{exists: 1'b1, wmask: 8'hff, hwmask: 8'h00, por: 8'h00, keep: 8'hff, rst: 8'h00};
      case (idx)
         6'h01: begin a.hwmask = 8'hfc; a.keep = 8'h23; end
         6'h02: begin a.wmask = 8'hfb; a.hwmask = 8'h20; a.keep = 8'hd9; end
         6'h03: begin a.wmask = 8'hf7; a.hwmask = 8'h47; a.por = 8'h14; a.keep = 8'hb0; a.rst = 8'h04; end
         6'h04: begin a.wmask = 8'h07; a.hwmask = 8'h03; a.keep = 8'h07; end
         6'h06: a.wmask = 8'he4;
         6'h07: a.wmask = 8'ha7;
         6'h08, 6'h09, 6'h22, 6'h34: a.wmask = 8'h3f;
         6'h0c, 6'h0d, 6'h11, 6'h12: a.wmask = 8'h77;
         6'h10: a.wmask = 8'h60;
         6'h1c: a.wmask = 8'h05;
         6'h20: a.wmask = 8'hf1;
         6'h26: a.wmask = 8'h7f;
         6'h2a: a.wmask = 8'h7d;
         6'h2b: a.wmask = 8'h0f;
         6'h3c: a.wmask = 8'h0d;
         6'h3d: a.wmask = 8'h03;
         6'h05, 6'h17, 6'h18, 6'h19, 6'h1e, 6'h21, 6'h23, 6'h24, 6'h25, 6'h27, 6'h28, 6'h29,
         6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33: a.wmask = 8'hff;
         default: a.exists = 1'b0;
      endcase
      return a;
   endfunction : ctrl_attr

   // Clearable status bits; wmask holds the clearable set
   function automatic reg_attr_type stat_attr(input logic [4:0] idx);
      reg_attr_type a;
      a = '{exists: 1'b1, wmask: 8'h00, hwmask: 8'h00, por: 8'h00, keep: 8'hff, rst: 8'h00};
      case (idx)
         5'h00: a.wmask = 8'h5f;
         5'h01: a.wmask = 8'hff;
         5'h02: a.wmask = 8'h07;
         5'h03: a.wmask = 8'hcf;
         5'h04: a.wmask = 8'h1f;
         5'h05: a.wmask = 8'h00;
         5'h06: a.wmask = 8'h37;
         5'h07: a.wmask = 8'h30;
         5'h14, 5'h15: a.wmask = 8'h0f;
         default: a.exists = 1'b0;
      endcase
      return a;
   endfunction : stat_attr

   // Address falls inside the status register window
   function automatic logic in_stat(input logic [6:0] a);
      return (a[6:5] == 2'b10) && (a[4:0] < 5'(STAT_REGS));
   endfunction : in_stat

endpackage : sbc_spi_pkg

// ==== verification/spi_master_model.sv ====
// Link master model that issues sixteen-bit command frames
`timescale 1ns/1ps
module spi_master_model
(
   // Clock
   input wire logic clk,
   // Link pins
   output logic spi_cs_n,
   output logic spi_clk,
   output logic spi_din,
   input wire logic spi_dout
);

   // ****************************************
   // Idle levels
   // ****************************************
   // Link clock stands still low outside frames
   initial
   begin
      spi_cs_n = 1'b1;
      spi_clk = 1'b0;
      spi_din = 1'b0;
   end

   // ****************************************
   // Frame transfer
   // ****************************************
   // Low phase 5 clk, high phase 3 clk: 64 ns period, margin for the pin synchronisers
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [15:0] rd);
      logic [15:0] f;
      f = {d, w, a};
      @(negedge clk);
      spi_cs_n = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         spi_din = f[i];
         repeat (i == 0 ? 6 : 4) @(negedge clk);
         rd[i] = spi_dout;
         spi_clk = 1'b1;
         repeat (3) @(negedge clk);
         spi_clk = 1'b0;
         @(negedge clk);
      end
      repeat (3) @(negedge clk);
      spi_cs_n = 1'b1;
      // Released line shows no stale value
      spi_din = ~spi_din;
   endtask : xfer

endmodule : spi_master_model

// ==== verification/sbc_spi_regs_tb.sv ====
// Self-checking bench for the serial register bank
`timescale 1ns/1ps
module sbc_spi_regs_tb
   import sbc_spi_pkg::*;
;
   logic clk, rst_n, spi_cs_n, spi_clk, spi_din, spi_dout, spi_dout_oe, soft_reset, restart_active;
   hw_upd_type hw_upd;
   logic [STAT_REGS-1:0][7:0] stat_set;
   logic [LIVE_REGS-1:0][7:0] live_status;
   logic [CTRL_REGS-1:0][7:0] ctrl_q;
   logic [7:0] status_field;
   cmd_event_type cmd_event;
   int errors = 0;
   int samples_checked = 0;
   logic [15:0] last_rd;
   localparam logic [7:0] FAMILY_ID_TB = 8'h3c; // Arbitrary value

   // ****************************************
   // Instances
   // ****************************************
   sbc_spi_regs #(.FAMILY_ID(FAMILY_ID_TB)) dut (.clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
      .spi_clk(spi_clk), .spi_din(spi_din),
      .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .soft_reset(soft_reset), .restart_active(restart_active),
      .hw_upd(hw_upd), .stat_set(stat_set), .live_status(live_status), .ctrl_q(ctrl_q),
      .status_field(status_field), .cmd_event(cmd_event));

   spi_master_model m (.clk(clk), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .spi_din(spi_din),
      .spi_dout(spi_dout));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One frame; read data only means something when the frame is accepted
   task automatic cmd(input logic [6:0] a, input logic w, input logic [7:0] d, input logic [7:0] exp,
      input logic ev);
      logic [15:0] rd;
      logic seen;
      seen = 1'b0;
      m.xfer(a, w, d, rd);
      last_rd = rd;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge clk);
         if (cmd_event.valid === 1'b1 && cmd_event.addr === a && cmd_event.write === w)
            seen = 1'b1;
      end
      chk("frame event", {7'h00, ev}, {7'h00, seen});
      if (ev)
         chk("read data", exp, rd[15:8]);
   endtask : cmd

   task automatic hw(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      hw_upd = '{valid: 1'b1, addr: a, data: d};
      @(negedge clk);
      hw_upd = '0;
      @(negedge clk);
   endtask : hw

   task automatic end_of_test();
      $display("Checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // ****************************************
   // Clock and sequence
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Inputs change on falling edges only
   initial
   begin
      rst_n = 1'b0;
      soft_reset = 1'b0;
      restart_active = 1'b0;
      hw_upd = '0;
      stat_set = '0;
      live_status = '0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      // Power-on values, whole-byte write, old value shown in the write frame
      cmd(7'h03, 1'b0, 8'h00, 8'h14, 1'b1);
      chk("ctrl 03", 8'h14, ctrl_q[6'h03]);
      cmd(7'h17, 1'b1, 8'ha5, 8'h00, 1'b1);
      chk("ctrl 17", 8'ha5, ctrl_q[6'h17]);
      chk("ctrl 18", 8'h00, ctrl_q[6'h18]);
      cmd(7'h05, 1'b1, 8'h5a, 8'h00, 1'b1);
      chk("ctrl 05", 8'h5a, ctrl_q[6'h05]);
      cmd(7'h17, 1'b0, 8'h5a, 8'ha5, 1'b1);
      cmd(7'h17, 1'b0, 8'h00, 8'ha5, 1'b1);
      // Ones into reserved places on purpose, then a well-behaved write
      cmd(7'h04, 1'b1, 8'hff, 8'h00, 1'b1);
      cmd(7'h04, 1'b1, 8'h03, 8'h07, 1'b1);
      cmd(7'h04, 1'b0, 8'h00, 8'h03, 1'b1);
      // Hardware reaches only its own bits
      cmd(7'h01, 1'b1, 8'h03, 8'h00, 1'b1);
      hw(7'h01, 8'hf0);
      chk("ctrl 01", 8'hf3, ctrl_q[6'h01]);
      hw(7'h17, 8'h00);
      chk("ctrl 17", 8'ha5, ctrl_q[6'h17]);
      cmd(7'h01, 1'b0, 8'h00, 8'hf3, 1'b1);
      // Status set, summary bit, clear by mode one
      @(negedge clk);
      stat_set[1] = 8'hff;
      @(negedge clk);
      stat_set = '0;
      @(negedge clk);
      chk("summary", 8'h01, status_field);
      cmd(7'h41, 1'b0, 8'h00, 8'hff, 1'b1);
      chk("frame summary", 8'h01, last_rd[7:0]);
      cmd(7'h41, 1'b1, 8'h00, 8'hff, 1'b1);
      cmd(7'h41, 1'b0, 8'h00, 8'h00, 1'b1);
      chk("summary", 8'h00, status_field);
      // Live levels and identifier cannot be cleared
      live_status = '1;
      cmd(7'h48, 1'b1, 8'h00, 8'hf7, 1'b1);
      cmd(7'h48, 1'b0, 8'h00, 8'hf7, 1'b1);
      cmd(7'h70, 1'b1, 8'h00, 8'h4f, 1'b1);
      cmd(7'h73, 1'b0, 8'h00, 8'hf0, 1'b1);
      cmd(7'h7e, 1'b1, 8'hff, FAMILY_ID_TB, 1'b1);
      cmd(7'h7e, 1'b0, 8'h00, FAMILY_ID_TB, 1'b1);
      // Hole in the map
      cmd(7'h7f, 1'b1, 8'hff, 8'h00, 1'b1);
      cmd(7'h7f, 1'b0, 8'h00, 8'h00, 1'b1);
      // Restart loads its values and shuts out the link
      cmd(7'h03, 1'b1, 8'hf7, 8'h14, 1'b1);
      @(negedge clk);
      restart_active = 1'b1;
      cmd(7'h17, 1'b1, 8'h00, 8'h00, 1'b0);
      restart_active = 1'b0;
      chk("ctrl 03", 8'hb4, ctrl_q[6'h03]);
      chk("ctrl 01", 8'h23, ctrl_q[6'h01]);
      cmd(7'h17, 1'b0, 8'h00, 8'ha5, 1'b1);
      // Soft reset brings power-on values back
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      cmd(7'h17, 1'b0, 8'h00, 8'h00, 1'b1);
      cmd(7'h03, 1'b0, 8'h00, 8'h14, 1'b1);
      end_of_test();
   end

endmodule : sbc_spi_regs_tb
